// *** design/irn_decode.sv ***
`timescale 1ns/10ps
module irn_decode
(
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic instrValid,
  input wire logic [irn_pkg::InstrWidth-1:0] instrWord,
  input wire logic [irn_pkg::PcWidth-1:0] returnStackTop,
  output logic stackPop,
  output logic pcLoad,
  output logic [irn_pkg::PcWidth-1:0] pcLoadValue,
  output logic pcIncrement,
  output logic fetchFlush,
  output logic globalIntEnableSet,
  output logic nopSeen
);
  import irn_pkg::*;

  irn_state_type state_ff;
  irn_state_type nxt_state;
  logic isRetInt;
  logic isNop;
  logic retExec;
  logic [PcWidth-1:0] pcLoadValue_ff;
  logic pcLoad_ff;
  logic intEnableSet_ff;
  logic [1:0] retCycleCount_ff;

  // A return starts its count at one and must stand at its full length once
  // the flush cycle has passed.
  localparam logic [1:0] RetCycleFirst = 2'h1;
  localparam logic [1:0] RetCycleTarget = 2'(RET_INT_CYCLES);

  irn_op_match u_match
  (
    .instrWord(instrWord),
    .isRetInt(isRetInt),
    .isNop(isNop)
  );

  // ---------------------------------------------------------------
  // Sequencing
  // ---------------------------------------------------------------
  // A valid word only executes outside the flush cycle; the pop and the
  // increment share this test so that they can never disagree on the slot.
  function automatic logic execSlot(input irn_state_type st, input logic valid);
    return (st == IRN_EXEC) && valid;
  endfunction

  // The word fetched behind an interrupt return is dead; the second cycle drops it.
  assign retExec = execSlot(state_ff, instrValid) && isRetInt;

  always_comb
  begin
    nxt_state = state_ff;
    case (state_ff)
      IRN_EXEC:
      begin
        if (retExec)
        begin
          nxt_state = IRN_FLUSH;
        end
      end
      IRN_FLUSH:
      begin
        nxt_state = IRN_EXEC;
      end
      default:
      begin
        nxt_state = IRN_EXEC;
      end
    endcase
  end

  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state_ff <= IRN_EXEC;
    end
    else
    begin
      state_ff <= nxt_state;
    end
  end

  // ---------------------------------------------------------------
  // Program counter and stack effects
  // ---------------------------------------------------------------
  assign stackPop = retExec;
  assign fetchFlush = (state_ff == IRN_FLUSH);
  // Idle and every other ordinary word only advance the counter.
  assign pcIncrement = execSlot(state_ff, instrValid) && !isRetInt;
  assign nopSeen = pcIncrement && isNop;

  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      pcLoadValue_ff <= '0;
      pcLoad_ff <= 1'b0;
    end
    else
    begin
      pcLoad_ff <= retExec;
      if (retExec)
      begin
        pcLoadValue_ff <= returnStackTop;
      end
    end
  end

  // Only the enable bit is touched; arithmetic flags have no path here.
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      intEnableSet_ff <= 1'b0;
    end
    else
    begin
      intEnableSet_ff <= retExec;
    end
  end

  assign pcLoad = pcLoad_ff;
  assign pcLoadValue = pcLoadValue_ff;
  assign globalIntEnableSet = intEnableSet_ff;

  // ---------------------------------------------------------------
  // Return length tracking
  // ---------------------------------------------------------------
  // Only the checks read this count; it restarts on every return so that a
  // flush stretched by a stuck state would show up as an overlong count.
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      retCycleCount_ff <= '0;
    end
    else if (retExec)
    begin
      retCycleCount_ff <= RetCycleFirst;
    end
    else if (fetchFlush)
    begin
      retCycleCount_ff <= retCycleCount_ff + RetCycleFirst;
    end
    else
    begin
      retCycleCount_ff <= '0;
    end
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  sequence s_ret_taken;
    instrValid && (state_ff == IRN_EXEC) && (instrWord == RET_INT_CODE);
  endsequence

  // The flush cycle of a return: dead word dropped, address and enable delivered.
  sequence s_flush_cycle;
    fetchFlush && pcLoad && globalIntEnableSet && !pcIncrement && !stackPop;
  endsequence

  // An idle word in an execute slot, with its don't-care bits masked off.
  sequence s_nop_taken;
    instrValid && (state_ff == IRN_EXEC) && ((instrWord & NOP_MASK) == NOP_CODE);
  endsequence

  chk_ret_decode: assert property (@(posedge ref_clk) disable iff (!reset_n)
    s_ret_taken |-> stackPop)
    else $error("Interrupt return word not decoded.");

  chk_pop_once: assert property (@(posedge ref_clk) disable iff (!reset_n)
    stackPop |=> !stackPop)
    else $error("Stack popped twice for one return.");

  chk_pc_restore: assert property (@(posedge ref_clk) disable iff (!reset_n)
    s_ret_taken |=> pcLoad && (pcLoadValue == $past(returnStackTop)))
    else $error("Program counter not restored from stack top.");

  chk_int_enable_set: assert property (@(posedge ref_clk) disable iff (!reset_n)
    s_ret_taken |=> globalIntEnableSet ##1 !globalIntEnableSet)
    else $error("Global interrupt enable not set once.");

  chk_two_cycles: assert property (@(posedge ref_clk) disable iff (!reset_n)
    s_ret_taken |=> fetchFlush && !pcIncrement ##1 !fetchFlush)
    else $error("Interrupt return did not take two cycles.");

  chk_nop_plain: assert property (@(posedge ref_clk) disable iff (!reset_n)
    nopSeen |-> pcIncrement && !stackPop ##1 !fetchFlush && !globalIntEnableSet)
    else $error("Idle op had side effects.");

  chk_flush_cause: assert property (@(posedge ref_clk) disable iff (!reset_n)
    fetchFlush |-> $past(stackPop))
    else $error("Flush without interrupt return.");

  chk_load_cause: assert property (@(posedge ref_clk) disable iff (!reset_n)
    pcLoad |-> fetchFlush && globalIntEnableSet)
    else $error("Load out of step with flush.");

  chk_ret_steps: assert property (@(posedge ref_clk) disable iff (!reset_n)
    s_ret_taken |=> s_flush_cycle)
    else $error("Return steps out of order.");

  chk_ret_length: assert property (@(posedge ref_clk) disable iff (!reset_n)
    fetchFlush |=> (retCycleCount_ff == RetCycleTarget))
    else $error("Interrupt return length wrong.");

  chk_flush_refuse: assert property (@(posedge ref_clk) disable iff (!reset_n)
    fetchFlush |-> !pcIncrement && !nopSeen && !stackPop)
    else $error("Word taken in flush cycle.");

  chk_nop_step: assert property (@(posedge ref_clk) disable iff (!reset_n)
    s_nop_taken |-> nopSeen && pcIncrement)
    else $error("Idle word not stepped over.");

  chk_load_hold: assert property (@(posedge ref_clk) disable iff (!reset_n)
    !stackPop |=> $stable(pcLoadValue))
    else $error("Restored address moved without a return.");
endmodule

// *** design/irn_op_match.sv ***
`timescale 1ns/10ps
module irn_op_match
(
  input wire logic [irn_pkg::InstrWidth-1:0] instrWord,
  output logic isRetInt,
  output logic isNop
);
  import irn_pkg::*;

  // Two bits of the idle encoding are don't-care, so the idle match is masked.
  assign isRetInt = (instrWord == RET_INT_CODE);
  assign isNop = ((instrWord & NOP_MASK) == NOP_CODE);
endmodule

// *** design/irn_pkg.sv ***
package irn_pkg;

  // ---------------------------------------------------------------
  // Instruction encodings
  // ---------------------------------------------------------------
  localparam int InstrWidth = 14;
  localparam int PcWidth = 13;
  localparam logic [13:0] RET_INT_CODE = 14'h0009;
  localparam logic [13:0] NOP_MASK = 14'h3f9f;
  localparam logic [13:0] NOP_CODE = 14'h0000;

  // ---------------------------------------------------------------
  // Interrupt control register layout
  // ---------------------------------------------------------------
  localparam int INT_ENABLE_BIT = 7;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int RET_INT_CYCLES = 2;

  typedef enum logic [1:0] {
    IRN_EXEC = 2'h1,
    IRN_FLUSH = 2'h2
  } irn_state_type;

endpackage

// *** sim/irn_core_model.sv ***
`timescale 1ns/10ps
module irn_core_model
(
  input wire logic ref_clk,
  input wire logic stackPop,
  output logic [irn_pkg::PcWidth-1:0] returnStackTop
);
  import irn_pkg::*;
  // The top moves on every pop, so a stale address cannot pass.
  initial returnStackTop = 13'h0a5c;
  always @(posedge ref_clk)
  begin
    if (stackPop)
    begin
      returnStackTop <= returnStackTop + 13'h0101;
    end
  end
endmodule

// *** sim/irn_decode_tb_top.sv ***
`timescale 1ns/10ps
module irn_decode_tb_top;
  import irn_pkg::*;
  logic ref_clk = 1'b0;
  logic reset_n = 1'b0;
  logic instrValid = 1'b0;
  logic [13:0] instrWord = 14'h0000;
  logic [12:0] top, expTop, pcLoadValue;
  logic stackPop, pcLoad, pcIncrement, fetchFlush, globalIntEnableSet, nopSeen;
  logic [5:0] outs;
  int n_fail = 0;
  int n_tests = 0;
  int cyc = 0;
  assign outs = {stackPop, pcLoad, fetchFlush, globalIntEnableSet, pcIncrement, nopSeen};
  irn_decode dut_u (.ref_clk(ref_clk), .reset_n(reset_n), .instrValid(instrValid),
    .instrWord(instrWord), .returnStackTop(top), .stackPop(stackPop), .pcLoad(pcLoad),
    .pcLoadValue(pcLoadValue), .pcIncrement(pcIncrement), .fetchFlush(fetchFlush),
    .globalIntEnableSet(globalIntEnableSet), .nopSeen(nopSeen));
  irn_core_model model_u (.ref_clk(ref_clk), .stackPop(stackPop), .returnStackTop(top));
  initial forever #10 ref_clk = ~ref_clk;
  task automatic finish_test;
    $display("checks %0d failures %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // Drives one word after the falling edge and judges the settled outputs.
  task automatic step(input logic v, input logic [13:0] w, input logic [5:0] e);
    @(negedge ref_clk);
    instrValid = v;
    instrWord = w;
    #1;
    n_tests++;
    if (outs !== e)
    begin
      n_fail++;
      $display("CHECK FAILED %0t word %h outs %b", $time, w, outs);
    end
  endtask
  task automatic test_ret;
    repeat (2)
    begin
      expTop = top;
      step(1'b1, 14'h0009, 6'b100000);
      step(1'b1, 14'h0000, 6'b011100);
      n_tests++;
      if (pcLoadValue !== expTop)
      begin
        n_fail++;
        $display("CHECK FAILED %0t restored address %h", $time, pcLoadValue);
      end
    end
    step(1'b1, 14'h0000, 6'b000011);
    $display("return test done");
  endtask
  task automatic test_nop;
    logic [13:0] w [4] = '{14'h0000, 14'h0020, 14'h0040, 14'h0060};
    foreach (w[i]) step(1'b1, w[i], 6'b000011);
    step(1'b1, 14'h0008, 6'b000010);
    step(1'b1, 14'h0001, 6'b000010);
    step(1'b0, 14'h0009, 6'b000000);
    $display("idle test done");
  endtask
  // Drops reset in the flush cycle of a return, then checks a clean restart.
  task automatic test_reset;
    step(1'b1, 14'h0009, 6'b100000);
    @(negedge ref_clk);
    instrValid = 1'b0;
    reset_n = 1'b0;
    #1;
    n_tests++;
    if (outs !== 6'b000000 || pcLoadValue !== 13'h0000)
    begin
      n_fail++;
      $display("CHECK FAILED %0t reset left outs %b", $time, outs);
    end
    @(negedge ref_clk);
    reset_n = 1'b1;
    expTop = top;
    step(1'b1, 14'h0009, 6'b100000);
    step(1'b1, 14'h0000, 6'b011100);
    n_tests++;
    if (pcLoadValue !== expTop)
    begin
      n_fail++;
      $display("CHECK FAILED %0t address after reset %h", $time, pcLoadValue);
    end
    $display("reset test done");
  endtask
  always @(posedge ref_clk)
  begin
    cyc++;
    if (cyc == 2000)
    begin
      n_fail++;
      finish_test();
    end
  end
  initial
  begin
    repeat (20) @(posedge ref_clk);
    @(negedge ref_clk);
    reset_n = 1'b1;
    test_ret();
    test_nop();
    test_reset();
    finish_test();
  end
endmodule
